// *** cmd_mode_ctrl.sv ***
// Purpose: Comparator mode register with edge flags, latch and routing
// Assumes: Raw comparator output arrives asynchronously; overflow pulse
//          from the counter array is on core_clk
// Notes:
// Function
// - Counter overflow samples the output into bit 7 until the next overflow or mode register write.
// - Bit 6 at 0 passes the comparator output as is, at 1 inverts it.
// - Rising-edge interrupts are allowed only while bit 5 is set.
// - Falling-edge interrupts are allowed only while bit 4 is set.
// - Routing 0 takes both inputs from the mux choices, DAC off.
// - Routing 1: positive choice, inverting input grounded, DAC off.
// - Routing 2: DAC on noninverting input, positive choice as reference.
// - Routing 3: DAC on inverting input, negative choice as reference.
// - Bits 1:0 select speed and power, 0 fastest and 3 slowest.
// - Each output transition sets its flag until software clears it.
// - Inversion acts right after the synchroniser so every consumer sees it.
`timescale 1ns/1ps
`include "cmd_defs.svh"

module cmd_mode_ctrl
   import cmd_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // Special-function register bus
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   // Flag clears from the control register
   input  wire logic       rise_flag_clr,
   input  wire logic       fall_flag_clr,
   // Comparator core and counter array
   input  wire logic       comparator_raw,
   input  wire logic       counter_overflow,
   output logic            comparator_out,
   output logic            rise_edge_flag,
   output logic            fall_edge_flag,
   output logic            comparator_irq,
   // Analog routing and speed controls
   output logic            pos_from_mux,
   output logic            pos_from_dac,
   output logic            neg_from_mux,
   output logic            neg_to_ground,
   output logic            neg_from_dac,
   output logic            dac_enable,
   output logic            dac_ref_from_pos,
   output logic            dac_ref_from_neg,
   output logic      [1:0] speed_power_select
);

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic       overflow_sampled_output_q;
   logic       output_polarity_flip_q;
   logic       rise_irq_enable_q;
   logic       fall_irq_enable_q;
   cmd_route_e input_routing_select_q;
   logic [1:0] speed_power_q;
   logic       raw_sync;
   logic       cmp_now;
   logic       cmp_prev_q;
   logic       prev_valid_q;
   logic       mode_hit;

   function automatic logic addr_hit(input logic [7:0] a);
      addr_hit = (a == `CMD_MODE_ADDR);
   endfunction

   assign mode_hit = addr_hit(sfr_addr);

   cmd_sync #(
      .STAGES (`CMD_SYNC_STAGES)
   ) u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .async_in (comparator_raw),
      .sync_out (raw_sync)
   );

   // Polarity applied once for all consumers
   assign cmp_now = raw_sync ^ output_polarity_flip_q;

   // ------------------------------------------------------------
   // Mode register write
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         output_polarity_flip_q <= 1'b0;
         rise_irq_enable_q      <= 1'b0;
         fall_irq_enable_q      <= 1'b0;
         input_routing_select_q <= CMD_ROUTE_MUX_MUX;
         speed_power_q          <= `CMD_SPEED_RESET;
      end else if (sfr_wr && mode_hit) begin
         output_polarity_flip_q <= sfr_wdata[`CMD_BIT_POLARITY];
         rise_irq_enable_q      <= sfr_wdata[`CMD_BIT_RISE_IE];
         fall_irq_enable_q      <= sfr_wdata[`CMD_BIT_FALL_IE];
         input_routing_select_q <=
            cmd_route_e'(sfr_wdata[`CMD_ROUTE_HI:`CMD_ROUTE_LO]);
         speed_power_q <= sfr_wdata[`CMD_SPEED_HI:`CMD_SPEED_LO];
      end
   end

   // ------------------------------------------------------------
   // Latched output: overflow sample wins over a software write
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         overflow_sampled_output_q <= 1'b0;
      end else if (counter_overflow) begin
         overflow_sampled_output_q <= cmp_now;
      end else if (sfr_wr && mode_hit) begin
         overflow_sampled_output_q <= sfr_wdata[`CMD_BIT_LATCHED];
      end
   end

   // ------------------------------------------------------------
   // Edge flags: set wins over clear
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cmp_prev_q   <= 1'b0;
         prev_valid_q <= 1'b0;
      end else begin
         cmp_prev_q   <= cmp_now;
         prev_valid_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rise_edge_flag <= 1'b0;
         fall_edge_flag <= 1'b0;
      end else begin
         if (prev_valid_q && cmp_now && !cmp_prev_q) begin
            rise_edge_flag <= 1'b1;
         end else if (rise_flag_clr) begin
            rise_edge_flag <= 1'b0;
         end
         if (prev_valid_q && !cmp_now && cmp_prev_q) begin
            fall_edge_flag <= 1'b1;
         end else if (fall_flag_clr) begin
            fall_edge_flag <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Interrupt request and comparator output
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         comparator_irq <= 1'b0;
         comparator_out <= 1'b0;
      end else begin
         // Enables gate flags as registered this cycle
         comparator_irq <=
            (rise_edge_flag && rise_irq_enable_q) ||
            (fall_edge_flag && fall_irq_enable_q);
         comparator_out <= cmp_now;
      end
   end

   // ------------------------------------------------------------
   // Analog routing decode
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pos_from_mux     <= 1'b1;
         pos_from_dac     <= 1'b0;
         neg_from_mux     <= 1'b1;
         neg_to_ground    <= 1'b0;
         neg_from_dac     <= 1'b0;
         dac_enable       <= 1'b0;
         dac_ref_from_pos <= 1'b0;
         dac_ref_from_neg <= 1'b0;
      end else begin
         case (input_routing_select_q)
            CMD_ROUTE_MUX_MUX: begin
               pos_from_mux     <= 1'b1;
               pos_from_dac     <= 1'b0;
               neg_from_mux     <= 1'b1;
               neg_to_ground    <= 1'b0;
               neg_from_dac     <= 1'b0;
               dac_enable       <= 1'b0;
               dac_ref_from_pos <= 1'b0;
               dac_ref_from_neg <= 1'b0;
            end
            CMD_ROUTE_MUX_GND: begin
               pos_from_mux     <= 1'b1;
               pos_from_dac     <= 1'b0;
               neg_from_mux     <= 1'b0;
               neg_to_ground    <= 1'b1;
               neg_from_dac     <= 1'b0;
               dac_enable       <= 1'b0;
               dac_ref_from_pos <= 1'b0;
               dac_ref_from_neg <= 1'b0;
            end
            CMD_ROUTE_DAC_MUX: begin
               pos_from_mux     <= 1'b0;
               pos_from_dac     <= 1'b1;
               neg_from_mux     <= 1'b1;
               neg_to_ground    <= 1'b0;
               neg_from_dac     <= 1'b0;
               dac_enable       <= 1'b1;
               dac_ref_from_pos <= 1'b1;
               dac_ref_from_neg <= 1'b0;
            end
            default: begin
               pos_from_mux     <= 1'b1;
               pos_from_dac     <= 1'b0;
               neg_from_mux     <= 1'b0;
               neg_to_ground    <= 1'b0;
               neg_from_dac     <= 1'b1;
               dac_enable       <= 1'b1;
               dac_ref_from_pos <= 1'b0;
               dac_ref_from_neg <= 1'b1;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Speed field and read data
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         speed_power_select <= `CMD_SPEED_RESET;
         sfr_rdata          <= 8'h00;
      end else begin
         speed_power_select <= speed_power_q;
         if (sfr_rd && mode_hit) begin
            sfr_rdata <= {overflow_sampled_output_q, output_polarity_flip_q,
                          rise_irq_enable_q, fall_irq_enable_q,
                          input_routing_select_q, speed_power_q};
         end else begin
            sfr_rdata <= 8'h00;
         end
      end
   end

endmodule

// *** cmd_defs.svh ***
// Purpose: Constants for the comparator mode register block
// Assumes: 8-bit special-function register bus
// Notes:   Included by the package and the design modules
`ifndef CMD_DEFS_SVH
`define CMD_DEFS_SVH

`define CMD_MODE_ADDR     8'h9d
`define CMD_MODE_RESET    8'h02
`define CMD_SPEED_RESET   2'h2
`define CMD_BIT_LATCHED   7
`define CMD_BIT_POLARITY  6
`define CMD_BIT_RISE_IE   5
`define CMD_BIT_FALL_IE   4
`define CMD_ROUTE_HI      3
`define CMD_ROUTE_LO      2
`define CMD_SPEED_HI      1
`define CMD_SPEED_LO      0
`define CMD_SYNC_STAGES   2

`endif

// *** cmd_pkg.sv ***
// Purpose: Types for the comparator mode register block
// Assumes: Constants come from cmd_defs.svh
// Notes:   Routing encodings follow the input routing field
`include "cmd_defs.svh"

package cmd_pkg;

   typedef enum logic [1:0] {
      CMD_ROUTE_MUX_MUX = 2'h0,
      CMD_ROUTE_MUX_GND = 2'h1,
      CMD_ROUTE_DAC_MUX = 2'h2,
      CMD_ROUTE_MUX_DAC = 2'h3
   } cmd_route_e;

   typedef enum logic [1:0] {
      CMD_SPEED_FASTEST = 2'h0,
      CMD_SPEED_FAST    = 2'h1,
      CMD_SPEED_SLOW    = 2'h2,
      CMD_SPEED_SLOWEST = 2'h3
   } cmd_speed_e;

endpackage

// *** cmd_sync.sv ***
// Purpose: Two-flop synchroniser for asynchronous single-bit inputs
// Assumes: One clock, synchronous active-high reset
// Notes:   Only the last stage may be read by logic
`timescale 1ns/1ps
`include "cmd_defs.svh"

module cmd_sync
   import cmd_pkg::*;
#(
   parameter int STAGES = `CMD_SYNC_STAGES
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // Data
   input  wire logic async_in,
   output logic      sync_out
);

   logic [STAGES-1:0] chain_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         chain_q <= '0;
      end else begin
         chain_q <= {chain_q[STAGES-2:0], async_in};
      end
   end

   assign sync_out = chain_q[STAGES-1];

endmodule

// *** cmd_mode_monitor.sv ***
// Purpose: Port assertions for the comparator mode register
// Assumes: Bound to cmd_mode_ctrl from the testbench top
// Notes:   Routing and speed judged three quiet cycles after a write
`timescale 1ns/1ps
module cmd_mode_monitor (
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       rst,
   // Register bus
   input wire logic       sfr_wr,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   // Flags and interrupt
   input wire logic       rise_flag_clr,
   input wire logic       fall_flag_clr,
   input wire logic       comparator_irq,
   input wire logic       rise_edge_flag,
   input wire logic       fall_edge_flag,
   // Routing and speed
   input wire logic       pos_from_mux,
   input wire logic       pos_from_dac,
   input wire logic       neg_from_mux,
   input wire logic       neg_to_ground,
   input wire logic       neg_from_dac,
   input wire logic       dac_enable,
   input wire logic       dac_ref_from_pos,
   input wire logic       dac_ref_from_neg,
   input wire logic [1:0] speed_power_select
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_mode_wr;
      sfr_wr && sfr_addr == 8'h9d;
   endsequence
   sequence s_quiet;
      s_mode_wr ##1 !sfr_wr [*3];
   endsequence
   a_speed_follow: assert property (
      s_quiet |-> speed_power_select == $past(sfr_wdata[1:0], 3))
      else $error("speed field not applied");
   a_route_mux: assert property (
      s_quiet |-> $past(sfr_wdata[3:2], 3) != 2'h0 ||
      (pos_from_mux && neg_from_mux && !dac_enable))
      else $error("route 0 wrong");
   a_route_gnd: assert property (
      s_quiet |-> $past(sfr_wdata[3:2], 3) != 2'h1 ||
      (pos_from_mux && neg_to_ground && !dac_enable))
      else $error("route 1 wrong");
   a_route_dacp: assert property (
      s_quiet |-> $past(sfr_wdata[3:2], 3) != 2'h2 ||
      (pos_from_dac && neg_from_mux && dac_ref_from_pos))
      else $error("route 2 wrong");
   a_route_dacn: assert property (
      s_quiet |-> $past(sfr_wdata[3:2], 3) != 2'h3 ||
      (pos_from_mux && neg_from_dac && dac_ref_from_neg))
      else $error("route 3 wrong");
   a_dac_tie: assert property (
      dac_enable == (pos_from_dac || neg_from_dac) &&
      $onehot({neg_from_mux, neg_to_ground, neg_from_dac}))
      else $error("dac enable mismatch");
   a_rise_sticky: assert property (
      rise_edge_flag && !rise_flag_clr |=> rise_edge_flag)
      else $error("rise flag dropped");
   a_fall_sticky: assert property (
      fall_edge_flag && !fall_flag_clr |=> fall_edge_flag)
      else $error("fall flag dropped");
   a_irq_cause: assert property (
      comparator_irq |-> $past(rise_edge_flag || fall_edge_flag))
      else $error("irq without flag");
endmodule

// *** cmd_far_model.sv ***
// Purpose: Comparator core and counter array stand-in
// Assumes: Testbench calls the tasks
// Notes:   Overflow is a one-cycle pulse on core_clk
`timescale 1ns/1ps
module cmd_far_model (
   // Clock
   input  wire logic core_clk,
   // Comparator core and counter array
   output logic      comparator_raw,
   output logic      counter_overflow
);
   initial begin
      comparator_raw   = 1'b0;
      counter_overflow = 1'b0;
   end
   task automatic set_level(input logic lvl);
      @(posedge core_clk);
      #1 comparator_raw = lvl;
   endtask
   task automatic overflow_pulse();
      @(posedge core_clk);
      #1 counter_overflow = 1'b1;
      @(posedge core_clk);
      #1 counter_overflow = 1'b0;
   endtask
endmodule

// *** test_comparator_mode_control.sv ***
// Purpose: Self-checking bench for the comparator mode register
// Assumes: Register bus strobes are one-cycle pulses
// Notes:   Waits cover the two-flop synchroniser plus output stages
`timescale 1ns/1ps
module test_comparator_mode_control;
   logic       core_clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rd_v;
   logic       rise_flag_clr = 1'b0, fall_flag_clr = 1'b0, comparator_out;
   logic       comparator_raw, counter_overflow, comparator_irq;
   logic       rise_edge_flag, fall_edge_flag, pos_from_mux, pos_from_dac;
   logic       neg_from_mux, neg_to_ground, neg_from_dac, dac_enable;
   logic       dac_ref_from_pos, dac_ref_from_neg;
   logic [1:0] speed_power_select;
   logic [7:0] route_tbl [4] = '{8'ha0, 8'h90, 8'h66, 8'h8d};
   wire  [7:0] route_v = {pos_from_mux, pos_from_dac, neg_from_mux,
      neg_to_ground, neg_from_dac, dac_enable, dac_ref_from_pos,
      dac_ref_from_neg};
   int         error_cnt = 0, n_compared = 0;
   always #2 core_clk = ~core_clk;
   cmd_far_model far (.core_clk, .comparator_raw, .counter_overflow);
   cmd_mode_ctrl dut (.core_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd,
      .sfr_wdata, .sfr_rdata, .rise_flag_clr, .fall_flag_clr,
      .comparator_raw, .counter_overflow, .comparator_out,
      .rise_edge_flag, .fall_edge_flag, .comparator_irq, .pos_from_mux,
      .pos_from_dac, .neg_from_mux, .neg_to_ground, .neg_from_dac,
      .dac_enable, .dac_ref_from_pos, .dac_ref_from_neg,
      .speed_power_select);
   task automatic chk(input logic [7:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge core_clk);
      #1 sfr_wr = 1'b1;
      sfr_addr = a;
      sfr_wdata = d;
      @(posedge core_clk);
      #1 sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      #1 sfr_rd = 1'b1;
      sfr_addr = a;
      @(posedge core_clk);
      #1 sfr_rd = 1'b0;
      rd_v = sfr_rdata;
   endtask
   task automatic clr();
      @(posedge core_clk);
      #1 {rise_flag_clr, fall_flag_clr} = 2'b11;
      @(posedge core_clk);
      #1 {rise_flag_clr, fall_flag_clr} = 2'b00;
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Whole run is about a hundred cycles
   initial begin
      #20000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      repeat (3) @(posedge core_clk);
      #1 rst = 1'b0;
      rd(8'h9d);
      chk(rd_v, 8'h02);
      chk(route_v, 8'ha0);
      wr(8'h9c, 8'hff);
      rd(8'h9d);
      chk(rd_v, 8'h02);
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         wr(8'h9d, {4'h0, i[1:0], i[1:0]});
         wait_n(3);
         rd(8'h9d);
         chk(rd_v, {4'h0, i[1:0], i[1:0]});
         chk(route_v, route_tbl[i]);
         chk(8'(speed_power_select), 8'(i[1:0]));
      end
      $display("routing test done");
      wr(8'h9d, 8'h00);
      far.set_level(1'b1);
      wait_n(6);
      chk(8'(comparator_out), 8'h01);
      clr();
      wr(8'h9d, 8'h50);
      wait_n(6);
      chk(8'(comparator_out), 8'h00);
      chk(8'(fall_edge_flag), 8'h01);
      chk(8'(rise_edge_flag), 8'h00);
      chk(8'(comparator_irq), 8'h01);
      wr(8'h9d, 8'h40);
      wait_n(2);
      chk(8'(fall_edge_flag), 8'h01);
      chk(8'(comparator_irq), 8'h00);
      clr();
      far.set_level(1'b0);
      wait_n(6);
      chk(8'(rise_edge_flag), 8'h01);
      chk(8'(comparator_irq), 8'h00);
      wr(8'h9d, 8'h60);
      wait_n(2);
      chk(8'(comparator_irq), 8'h01);
      clr();
      wait_n(2);
      chk(8'(comparator_irq), 8'h00);
      far.overflow_pulse();
      wait_n(2);
      rd(8'h9d);
      chk(8'(rd_v[7]), 8'h01);
      far.set_level(1'b1);
      wait_n(6);
      rd(8'h9d);
      chk(8'(rd_v[7]), 8'h01);
      far.overflow_pulse();
      wait_n(2);
      rd(8'h9d);
      chk(8'(rd_v[7]), 8'h00);
      $display("edge and latch test done");
      print_verdict();
   end
endmodule
bind cmd_mode_ctrl cmd_mode_monitor mon (.core_clk, .rst, .sfr_wr,
   .sfr_addr, .sfr_wdata, .rise_flag_clr, .fall_flag_clr,
   .comparator_irq, .rise_edge_flag, .fall_edge_flag, .pos_from_mux,
   .pos_from_dac, .neg_from_mux, .neg_to_ground, .neg_from_dac,
   .dac_enable, .dac_ref_from_pos, .dac_ref_from_neg,
   .speed_power_select);
